// ### include/bbce_pkg.sv
// package for the bit branch count execute block
//
// Notes on behaviour
// - subroutine branch pushes return and status, jumps
// - long displacement is 24-bit two's complement
// - short 9-bit displacement is sign-extended
// - register form adds selected address register
// - bit set: push and branch by displacement
// - bit clear: only advance, no push
// - address register update happens regardless
// - conditional displacement from extension word
// - stack high source decrements stack pointer
// - bit number limited to 0 through 23
// - bit test copies bit into carry
// - stack high operand decrements pointer, else unchanged
// - short io forms reach top two 64-windows
// - count leading bits from bit 55 down
// - middle part gets nine minus count
// - low part zero, extension sign-extended
// - all-zero source gives zero result
// - sixteen-bit mode ignores low 8 bits of middle and low parts
// - flags: n bit 47, z middle zero, v clear
// - test-and-set copies carry, writes bit set, locked in memory forms only
package bbce_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int WORD_W = 24;
    localparam int ACC_W = 56;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_LO = 0;      // bit number field low bit
    localparam int SPACE_POS = 6;   // memory space select bit
    localparam int FLD_LO = 8;      // six-bit address/register field
    localparam int MODE_POS = 14;   // low/high address form selector
    localparam int RN_LO = 8;       // address register select

    // ************************************************************
    // condition code bit positions
    // ************************************************************
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;

    // ************************************************************
    // register direct code of stack high
    // ************************************************************
    localparam logic [5:0] REG_SSH = 6'h3C;

    // ************************************************************
    // io windows
    // ************************************************************
    localparam logic [23:0] IO_HI_BASE = 24'hFFFFC0;
    localparam logic [23:0] IO_LO_BASE = 24'hFFFF80;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [23:0] PC_RST = 24'h000000;
    localparam logic [7:0] CCR_RST = 8'h00;
    localparam logic [4:0] SP_RST = 5'h00;

    // ************************************************************
    // instruction classes and addressing kinds
    // ************************************************************
    typedef enum logic [3:0] {
        BBCE_OP_NONE = 4'h0,
        BBCE_OP_BSR_LONG = 4'h1,
        BBCE_OP_BSR_SHORT = 4'h2,
        BBCE_OP_BSR_REG = 4'h3,
        BBCE_OP_BRANCH_SUBROUTINE_IF_SET_OP = 4'h4,
        BBCE_OP_BIT_TEST_OP = 4'h5,
        BBCE_OP_BIT_TEST_AND_SET_OP = 4'h6,
        BBCE_OP_CLB = 4'h7
    } bbce_op_t;

    typedef enum logic [2:0] {
        BBCE_AM_EA = 3'h0,
        BBCE_AM_ABS = 3'h1,
        BBCE_AM_PP = 3'h2,
        BBCE_AM_QQ = 3'h3,
        BBCE_AM_REG = 3'h4
    } bbce_am_t;

    // ************************************************************
    // execution sequence (gray coded)
    // ************************************************************
    typedef enum logic [2:0] {
        BBCE_ST_IDLE = 3'b000,
        BBCE_ST_EXT = 3'b001,
        BBCE_ST_READ = 3'b011,
        BBCE_ST_WRITE = 3'b010,
        BBCE_ST_DONE = 3'b110
    } bbce_st_t;

endpackage

// ### logic/bbce_core.sv
// decode and execute of bit test, subroutine branch and count leading bits
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module bbce_core #(
    parameter int STACK_W = 5
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic instr_valid,          // opcode word offered
    input wire logic [23:0] instr_word,
    input wire logic [23:0] ext_word,      // extension word
    input wire logic ext_valid,
    output logic instr_ready,              // ready for next opcode
    input wire logic [23:0] pc_in,         // pc of the opcode
    input wire logic [23:0] sr_in,         // current status register
    input wire logic sixteen_bit_mode,
    input wire logic [191:0] addr_regs,    // r0..r7 packed
    input wire logic [23:0] ea_addr,       // computed effective address
    output logic ea_update,                // commit address reg update
    input wire logic [23:0] reg_rdata,     // register direct operand
    input wire logic [55:0] acc_a,
    input wire logic [55:0] acc_b,
    output logic mem_req,
    output logic mem_we,
    output logic mem_lock,                 // held across rmw
    output logic mem_space_y,
    output logic [23:0] mem_addr,
    output logic [23:0] mem_wdata,
    input wire logic [23:0] mem_rdata,     // sampled at the end of the req cycle
    output logic reg_we,
    output logic [5:0] reg_sel,
    output logic [23:0] reg_wdata,
    output logic [23:0] pc_q,
    output logic pc_load,
    output logic stack_push,
    output logic [23:0] stack_high_wdata,
    output logic [23:0] stack_low_wdata,
    output logic [STACK_W-1:0] stack_pointer_q,
    output logic [7:0] ccr_q,
    output logic acc_we,
    output logic acc_dst_b,
    output logic [55:0] acc_wdata
);

    // ************************************************************
    // decode function
    // ************************************************************
    function automatic bbce_pkg::bbce_op_t dec_op(input logic [23:0] w);
        bbce_pkg::bbce_op_t o;
        o = bbce_pkg::BBCE_OP_NONE;
        if (w == 24'h0D1080) begin
            o = bbce_pkg::BBCE_OP_BSR_LONG;
        end else if (w[23:16] == 8'h05 && w[15:10] == 6'h02
                     && w[5] == 1'b0) begin
            o = bbce_pkg::BBCE_OP_BSR_SHORT;
        end else if (w[23:11] == 13'h01A3 && w[7:0] == 8'h80) begin
            o = bbce_pkg::BBCE_OP_BSR_REG;
        end else if ((w[23:16] == 8'h0D || w[23:16] == 8'h04)
                     && w[15] && w[5]) begin
            o = bbce_pkg::BBCE_OP_BRANCH_SUBROUTINE_IF_SET_OP;
        end else if ((w[23:16] == 8'h0B || (w[23:16] == 8'h01
                     && w[15:14] == 2'b01)) && w[7] == 1'b0
                     && w[5] == 1'b1) begin
            // bit 4 is part of the bit number, so 16..23 decode too
            o = bbce_pkg::BBCE_OP_BIT_TEST_OP;
        end else if ((w[23:16] == 8'h0A || (w[23:16] == 8'h01
                     && w[15:14] == 2'b00)) && w[7] == 1'b0
                     && w[5] == 1'b1) begin
            o = bbce_pkg::BBCE_OP_BIT_TEST_AND_SET_OP;
        end else if (w[23:2] == 22'h030780) begin
            o = bbce_pkg::BBCE_OP_CLB;
        end
        return o;
    endfunction

    // ************************************************************
    // addressing kind
    // ************************************************************
    function automatic bbce_pkg::bbce_am_t dec_am(input logic [23:0] w,
                                                   input logic br);
        bbce_pkg::bbce_am_t a;
        a = bbce_pkg::BBCE_AM_EA;
        if (w[23:16] == 8'h04 || w[23:16] == 8'h01) begin
            a = bbce_pkg::BBCE_AM_QQ;
        end else if (br) begin
            unique case ({w[14], w[7]})
                2'b00: a = bbce_pkg::BBCE_AM_EA;
                2'b01: a = bbce_pkg::BBCE_AM_ABS;
                2'b10: a = bbce_pkg::BBCE_AM_PP;
                2'b11: a = bbce_pkg::BBCE_AM_REG;
            endcase
        end else begin
            unique case (w[15:14])
                2'b01: a = bbce_pkg::BBCE_AM_EA;
                2'b00: a = bbce_pkg::BBCE_AM_ABS;
                2'b10: a = bbce_pkg::BBCE_AM_PP;
                2'b11: a = bbce_pkg::BBCE_AM_REG;
            endcase
        end
        return a;
    endfunction

    // ************************************************************
    // latched instruction state
    // ************************************************************
    bbce_pkg::bbce_st_t st_q;
    bbce_pkg::bbce_op_t op_q;        // class in flight
    bbce_pkg::bbce_am_t am_q;        // operand kind
    logic [23:0] iw_q;               // opcode word
    logic [23:0] opc_q;              // its pc
    logic [23:0] opnd_q;             // fetched operand
    logic [23:0] disp_q;             // extension displacement
    logic tbit;                      // selected operand bit
    logic [4:0] bnum;                // bit number field
    logic [23:0] op_addr;            // operand address
    logic [23:0] rn_val;             // selected address register

    assign bnum = iw_q[4:0];
    assign rn_val = addr_regs[iw_q[10:8]*24 +: 24];
    // bit numbers above 23 test nothing and read zero
    assign tbit = (bnum <= 5'd23) ? opnd_q[bnum] : 1'b0;

    // ************************************************************
    // operand address for memory forms
    // ************************************************************
    always_comb begin
        unique case (am_q)
            bbce_pkg::BBCE_AM_ABS: op_addr = {18'h00000, iw_q[13:8]};
            bbce_pkg::BBCE_AM_PP:
                op_addr = bbce_pkg::IO_HI_BASE | {18'h00000, iw_q[13:8]};
            bbce_pkg::BBCE_AM_QQ:
                op_addr = bbce_pkg::IO_LO_BASE | {18'h00000, iw_q[13:8]};
            default: op_addr = ea_addr;
        endcase
    end

    // ************************************************************
    // count leading bits datapath
    // ************************************************************
    logic [55:0] clb_src;
    logic [55:0] clb_scan;
    logic [5:0] clb_cnt;
    logic clb_run;
    logic [23:0] clb_mid;
    always_comb begin
        clb_src = iw_q[1] ? acc_b : acc_a;
        clb_scan = clb_src;
        if (sixteen_bit_mode) begin
            // drop unused low bytes of middle and low parts
            clb_scan = {clb_src[55:48], clb_src[47:32],
                        clb_src[23:8], 16'h0000};
        end
        clb_cnt = 6'd0;
        clb_run = 1'b1;
        for (int i = 55; i >= 0; i--) begin
            if (clb_run && clb_scan[i] == clb_scan[55]) begin
                clb_cnt = clb_cnt + 6'd1;
            end else begin
                clb_run = 1'b0;
            end
        end
        if (sixteen_bit_mode && clb_cnt > 6'd40) begin
            clb_cnt = 6'd40;
        end
        if (clb_src == 56'h0) begin
            clb_mid = 24'h000000;
        end else begin
            clb_mid = 24'd9 - {18'h00000, clb_cnt};
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    logic is_br;
    assign is_br = (op_q == bbce_pkg::BBCE_OP_BRANCH_SUBROUTINE_IF_SET_OP);
    assign instr_ready = (st_q == bbce_pkg::BBCE_ST_IDLE);

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= bbce_pkg::BBCE_ST_IDLE;
            op_q <= bbce_pkg::BBCE_OP_NONE;
            am_q <= bbce_pkg::BBCE_AM_EA;
            iw_q <= 24'h000000;
            opc_q <= bbce_pkg::PC_RST;
            disp_q <= 24'h000000;
            opnd_q <= 24'h000000;
        end else begin
            unique case (st_q)
                bbce_pkg::BBCE_ST_IDLE: begin
                    if (instr_valid && dec_op(instr_word)
                            != bbce_pkg::BBCE_OP_NONE) begin
                        iw_q <= instr_word;
                        opc_q <= pc_in;
                        op_q <= dec_op(instr_word);
                        am_q <= dec_am(instr_word, dec_op(instr_word)
                                == bbce_pkg::BBCE_OP_BRANCH_SUBROUTINE_IF_SET_OP);
                        st_q <= bbce_pkg::BBCE_ST_EXT;
                    end
                end
                bbce_pkg::BBCE_ST_EXT: begin
                    // long forms wait on the extension word
                    if (op_q == bbce_pkg::BBCE_OP_BSR_LONG || is_br) begin
                        if (ext_valid) begin
                            disp_q <= ext_word;
                            st_q <= bbce_pkg::BBCE_ST_READ;
                        end
                    end else begin
                        st_q <= bbce_pkg::BBCE_ST_READ;
                    end
                end
                bbce_pkg::BBCE_ST_READ: begin
                    if (am_q == bbce_pkg::BBCE_AM_REG) begin
                        opnd_q <= reg_rdata;
                    end else begin
                        opnd_q <= mem_rdata;
                    end
                    st_q <= (op_q == bbce_pkg::BBCE_OP_BIT_TEST_AND_SET_OP)
                            ? bbce_pkg::BBCE_ST_WRITE
                            : bbce_pkg::BBCE_ST_DONE;
                end
                bbce_pkg::BBCE_ST_WRITE: begin
                    st_q <= bbce_pkg::BBCE_ST_DONE;
                end
                bbce_pkg::BBCE_ST_DONE: begin
                    st_q <= bbce_pkg::BBCE_ST_IDLE;
                end
                default: st_q <= bbce_pkg::BBCE_ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // operand access strobes
    // ************************************************************
    logic needs_opnd;
    logic mem_form;
    assign needs_opnd = (op_q == bbce_pkg::BBCE_OP_BRANCH_SUBROUTINE_IF_SET_OP)
                        || (op_q == bbce_pkg::BBCE_OP_BIT_TEST_OP)
                        || (op_q == bbce_pkg::BBCE_OP_BIT_TEST_AND_SET_OP);
    assign mem_form = needs_opnd && (am_q != bbce_pkg::BBCE_AM_REG);
    // read issued in the read step, written back in the write step
    assign mem_req = mem_form && ((st_q == bbce_pkg::BBCE_ST_READ)
                     || (st_q == bbce_pkg::BBCE_ST_WRITE));
    assign mem_we = mem_form && (st_q == bbce_pkg::BBCE_ST_WRITE);
    assign mem_lock = mem_form && (op_q == bbce_pkg::BBCE_OP_BIT_TEST_AND_SET_OP)
                      && ((st_q == bbce_pkg::BBCE_ST_READ)
                      || (st_q == bbce_pkg::BBCE_ST_WRITE));
    assign mem_space_y = iw_q[bbce_pkg::SPACE_POS];
    assign mem_addr = op_addr;
    assign mem_wdata = opnd_q | (24'h000001 << bnum);
    assign reg_sel = iw_q[13:8];
    assign reg_we = (op_q == bbce_pkg::BBCE_OP_BIT_TEST_AND_SET_OP)
                    && (am_q == bbce_pkg::BBCE_AM_REG)
                    && (st_q == bbce_pkg::BBCE_ST_WRITE);
    assign reg_wdata = mem_wdata;
    // address update committed whatever the branch outcome
    assign ea_update = needs_opnd && (am_q == bbce_pkg::BBCE_AM_EA)
                       && (st_q == bbce_pkg::BBCE_ST_DONE);

    // ************************************************************
    // branch target and push decision
    // ************************************************************
    logic take;
    logic [23:0] disp;
    logic [23:0] ret_pc;
    logic from_ssh;
    always_comb begin
        unique case (op_q)
            bbce_pkg::BBCE_OP_BSR_SHORT:
                disp = {{15{iw_q[9]}}, iw_q[9:6], iw_q[4:0]};
            bbce_pkg::BBCE_OP_BSR_REG: disp = rn_val;
            default: disp = disp_q;
        endcase
        take = (op_q == bbce_pkg::BBCE_OP_BSR_LONG)
               || (op_q == bbce_pkg::BBCE_OP_BSR_SHORT)
               || (op_q == bbce_pkg::BBCE_OP_BSR_REG)
               || (is_br && tbit);
    end
    assign ret_pc = opc_q + ((op_q == bbce_pkg::BBCE_OP_BSR_LONG
                    || is_br) ? 24'h000002 : 24'h000001);
    assign from_ssh = needs_opnd && (am_q == bbce_pkg::BBCE_AM_REG)
                      && (iw_q[13:8] == bbce_pkg::REG_SSH);

    assign stack_push = take && (st_q == bbce_pkg::BBCE_ST_DONE);
    assign stack_high_wdata = ret_pc;
    assign stack_low_wdata = sr_in;
    assign pc_load = (st_q == bbce_pkg::BBCE_ST_DONE);

    // ************************************************************
    // program counter
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            pc_q <= bbce_pkg::PC_RST;
        end else if (st_q == bbce_pkg::BBCE_ST_DONE) begin
            if (take) begin
                pc_q <= opc_q + disp;
            end else begin
                pc_q <= ret_pc;
            end
        end
    end

    // ************************************************************
    // stack pointer: stack-high read pops one level
    // ************************************************************
    localparam logic [STACK_W-1:0] SP_STEP = STACK_W'(1); // one level
    always_ff @(posedge clk) begin
        if (srst) begin
            stack_pointer_q <= STACK_W'(bbce_pkg::SP_RST);
        end else if (from_ssh && st_q == bbce_pkg::BBCE_ST_READ) begin
            stack_pointer_q <= stack_pointer_q - SP_STEP;
        end else if (stack_push) begin
            stack_pointer_q <= stack_pointer_q + SP_STEP;
        end
    end

    // ************************************************************
    // condition codes
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            ccr_q <= bbce_pkg::CCR_RST;
        end else if (st_q == bbce_pkg::BBCE_ST_DONE) begin
            if (op_q == bbce_pkg::BBCE_OP_BIT_TEST_OP
                    || op_q == bbce_pkg::BBCE_OP_BIT_TEST_AND_SET_OP) begin
                ccr_q[bbce_pkg::CC_C] <= tbit;
            end else if (op_q == bbce_pkg::BBCE_OP_CLB) begin
                ccr_q[bbce_pkg::CC_N] <= clb_mid[23];
                ccr_q[bbce_pkg::CC_Z] <= (clb_mid == 24'h000000);
                ccr_q[bbce_pkg::CC_V] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // accumulator result
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_we <= 1'b0;
            acc_dst_b <= 1'b0;
            acc_wdata <= 56'h0;
        end else begin
            acc_we <= (op_q == bbce_pkg::BBCE_OP_CLB)
                      && (st_q == bbce_pkg::BBCE_ST_READ);
            acc_dst_b <= iw_q[0];
            acc_wdata <= {{8{clb_mid[23]}}, clb_mid, 24'h000000};
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    no_push_clear_a: assert property (@(posedge clk) disable iff (srst)
        (st_q == bbce_pkg::BBCE_ST_DONE && is_br && !tbit) |-> !stack_push)
        else $error("push on clear tested bit");
    pc_seq_a: assert property (@(posedge clk) disable iff (srst)
        (st_q == bbce_pkg::BBCE_ST_DONE && !take)
        |=> pc_q == $past(ret_pc))
        else $error("pc not sequential");
    pc_branch_a: assert property (@(posedge clk) disable iff (srst)
        (st_q == bbce_pkg::BBCE_ST_DONE && take)
        |=> pc_q == $past(opc_q) + $past(disp))
        else $error("branch target wrong");
    carry_copy_a: assert property (@(posedge clk) disable iff (srst)
        (st_q == bbce_pkg::BBCE_ST_DONE && op_q == bbce_pkg::BBCE_OP_BIT_TEST_OP)
        |=> ccr_q[0] == $past(tbit))
        else $error("carry not bit");
    clb_flags_a: assert property (@(posedge clk) disable iff (srst)
        (st_q == bbce_pkg::BBCE_ST_DONE && op_q == bbce_pkg::BBCE_OP_CLB)
        |=> !ccr_q[1] && ccr_q[3] == acc_wdata[47])
        else $error("clb flags wrong");
    clb_low_a: assert property (@(posedge clk) disable iff (srst)
        acc_we |-> acc_wdata[23:0] == 24'h0
        && acc_wdata[55:48] == {8{acc_wdata[47]}})
        else $error("clb fill wrong");
    rmw_lock_a: assert property (@(posedge clk) disable iff (srst)
        (mem_req && !mem_we && op_q == bbce_pkg::BBCE_OP_BIT_TEST_AND_SET_OP)
        |=> mem_we && mem_lock)
        else $error("rmw not locked");
    ea_upd_a: assert property (@(posedge clk) disable iff (srst)
        (st_q == bbce_pkg::BBCE_ST_DONE && is_br
         && am_q == bbce_pkg::BBCE_AM_EA) |-> ea_update)
        else $error("ea update missed");
    sp_pop_a: assert property (@(posedge clk) disable iff (srst)
        (st_q == bbce_pkg::BBCE_ST_READ && from_ssh)
        |=> stack_pointer_q == $past(stack_pointer_q) - SP_STEP)
        else $error("stack high read not popped");

endmodule

// ### bench/bbce_tb.sv
// self-checking bench for the bit branch count execute block
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, ext_valid = 1'b0;
    logic sbm = 1'b0;
    logic [23:0] iw = 24'h0, xw = 24'h0, pc_in = 24'h0, sr_in = 24'h0;
    logic [23:0] ea = 24'h0, rd = 24'h0, md = 24'h0;
    logic [191:0] ar = 192'h0;
    logic [55:0] aa = 56'h12345678ABCDEF, ab = 56'h0;
    logic rdy, eau, mrq, mwe, mlk, pld, spu, awe, adb, msy, rwe;
    logic [23:0] ma, mwd, pcq, shw, slw, rwd;
    logic [5:0] rsl, sel;
    logic xwait = 1'b0;
    logic [4:0] spq;
    logic [7:0] condition_code_register;
    logic [55:0] awd;
    int failures = 0, checks_done = 0, cyc = 0;
    // values caught while one instruction runs
    logic psh, eas, lk, spc;
    logic [23:0] sh, sl, maddr, wd;
    logic [55:0] acc;
    bbce_core u_dut (.clk(clk), .srst(srst), .instr_valid(instr_valid),
        .instr_word(iw), .ext_word(xw), .ext_valid(ext_valid),
        .instr_ready(rdy), .pc_in(pc_in), .sr_in(sr_in),
        .sixteen_bit_mode(sbm), .addr_regs(ar), .ea_addr(ea),
        .ea_update(eau), .reg_rdata(rd), .acc_a(aa), .acc_b(ab),
        .mem_req(mrq), .mem_we(mwe), .mem_lock(mlk), .mem_space_y(msy),
        .mem_addr(ma), .mem_wdata(mwd), .mem_rdata(md), .reg_we(rwe),
        .reg_sel(rsl), .reg_wdata(rwd), .pc_q(pcq), .pc_load(pld),
        .stack_push(spu), .stack_high_wdata(shw), .stack_low_wdata(slw),
        .stack_pointer_q(spq), .ccr_q(condition_code_register), .acc_we(awe),
        .acc_dst_b(adb), .acc_wdata(awd));
    always #20 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [55:0] got, input logic [55:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // issue one instruction, gather strobes until the pc load
    task automatic run(input logic [23:0] w, input logic [23:0] x);
        psh = 1'b0;
        eas = 1'b0;
        lk = 1'b0;
        wd = 24'h0;
        acc = 56'h0;
        @(posedge clk);
        instr_valid <= 1'b1;
        iw <= w;
        xw <= xwait ? 24'h0 : x;
        ext_valid <= !xwait;
        @(posedge clk);
        instr_valid <= 1'b0;
        // late extension word: the design must wait for it
        if (xwait) begin
            repeat (2) @(posedge clk);
            xw <= x;
            ext_valid <= 1'b1;
        end
        repeat (20) begin
            #1;
            if (spu === 1'b1) begin
                psh = 1'b1;
                sh = shw;
                sl = slw;
            end
            if (mrq === 1'b1) begin
                maddr = ma;
                spc = msy;
            end
            if (rwe === 1'b1) begin
                wd = rwd;
                sel = rsl;
            end
            if (mwe === 1'b1) begin
                wd = mwd;
                lk = mlk;
            end
            if (eau === 1'b1) eas = 1'b1;
            if (awe === 1'b1) acc = awd;
            if (pld === 1'b1) break;
            @(posedge clk);
        end
        chk(pld, 1'b1);
        @(posedge clk);
        #1;
    endtask
    task automatic t_bsr();
        sr_in <= 24'h0000C5;
        pc_in <= 24'h000100;
        xwait = 1'b1;
        run(24'h0D1080, 24'hFFFFF0);
        xwait = 1'b0;
        chk(sh, 24'h000102);
        chk(sl, 24'h0000C5);
        chk(pcq, 24'h0000F0);
        pc_in <= 24'h000200;
        run(24'h050BDF, 24'h0);
        chk(sh, 24'h000201);
        chk(pcq, 24'h0001FF);
        ar <= 192'h40 << 120;
        pc_in <= 24'h000300;
        run(24'h0D1D80, 24'h0);
        chk(pcq, 24'h000340);
        chk(spq, 5'h03);
    endtask
    task automatic t_cond();
        rd <= 24'h800000;
        pc_in <= 24'h000400;
        run(24'h0DFCB7, 24'h000010);
        chk(sh, 24'h000402);
        chk(pcq, 24'h000410);
        chk(spq, 5'h03);
        ea <= 24'h000123;
        md <= 24'hFFFFFE;
        run(24'h0D9920, 24'h000010);
        chk(psh, 1'b0);
        chk(eas, 1'b1);
        chk(spq, 5'h03);
        chk(pcq, 24'h000402);
        chk(maddr, 24'h000123);
    endtask
    task automatic t_bit_test_op();
        md <= 24'h000008;
        run(24'h0B8523, 24'h0);
        chk(condition_code_register[0], 1'b1);
        chk(maddr, 24'hFFFFC5);
        chk(spc, 1'b0);
        run(24'h014564, 24'h0);
        chk(condition_code_register[0], 1'b0);
        chk(maddr, 24'hFFFF85);
        chk(spc, 1'b1);
        rd <= 24'h004000;
        run(24'h0BFC6E, 24'h0);
        chk(condition_code_register[0], 1'b1);
        chk(spq, 5'h02);
        run(24'h0A8522, 24'h0);
        chk(wd, 24'h00000C);
        chk(lk, 1'b1);
        chk(condition_code_register[0], 1'b0);
        md <= 24'h100000;
        run(24'h0B2134, 24'h0);
        chk(condition_code_register[0], 1'b1);
        chk(maddr, 24'h000021);
        rd <= 24'h000001;
        run(24'h0AC465, 24'h0);
        chk(wd, 24'h000021);
        chk(sel, 6'h04);
        chk(condition_code_register[0], 1'b0);
    endtask
    task automatic t_clb();
        logic [55:0] src [6];
        logic [23:0] mid [6];
        src = '{56'h80000000000000, 56'hFFF00000000000, 56'h0, 56'h1,
            56'h00400000000000, 56'h100};
        mid = '{24'h000008, 24'hFFFFFD, 24'h0, 24'hFFFFD2, 24'h0,
            24'hFFFFE2};
        for (int i = 0; i < 6; i++) begin
            ab <= src[i];
            sbm <= (i == 5);
            run(24'h0C1E02, 24'h0);
            chk(acc[47:24], mid[i]);
            chk(acc[55:48], {8{mid[i][23]}});
            chk(acc[23:0], 24'h0);
            chk(condition_code_register[3:1], {mid[i][23], mid[i] == 24'h0, 1'b0});
            chk(adb, 1'b0);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk(pcq, bbce_pkg::PC_RST);
        chk(spq, bbce_pkg::SP_RST);
        chk(rdy, 1'b1);
        t_bsr();
        t_cond();
        t_bit_test_op();
        t_clb();
        complete_run();
    end
endmodule
